// File: core/nvic_pkg.sv
// Purpose: Constants for the nested vectored interrupt controller.
// Assumes: Single 20 MHz clock, AHB-Lite word access only.
// Notes: Offsets are byte offsets inside the 4 KB controller window.
package nvic_pkg;
    localparam int NUM_IRQ = 30;
    localparam logic [11:0] OFS_SET_ENABLE = 12'h100;
    localparam logic [11:0] OFS_CLR_ENABLE = 12'h180;
    localparam logic [11:0] OFS_SET_PENDING = 12'h200;
    localparam logic [11:0] OFS_CLR_PENDING = 12'h280;
    localparam logic [11:0] OFS_ACTIVE = 12'h300;
    localparam logic [11:0] OFS_PRIO_BASE = 12'h400;
    localparam logic [11:0] OFS_PRIO_LAST = 12'h41C;
    localparam logic [11:0] OFS_GROUPING = 12'hD0C;
    localparam logic [11:0] OFS_SW_TRIGGER = 12'hF00;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    localparam logic [3:0] RESET_PRIO = 4'h0;
    localparam logic [2:0] RESET_GROUPING = 3'h0;
    localparam int PRIO_LSB = 0;
    localparam int CLK_NS = 50;
    localparam int STACK_NS = 400;
    localparam int STACK_CYCLES = (STACK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] STACK_LAST = 4'(STACK_CYCLES - 1);
    typedef enum logic [3:0] {
        SEL_NONE, SEL_SET_EN, SEL_CLR_EN, SEL_SET_PEND, SEL_CLR_PEND,
        SEL_ACTIVE, SEL_PRIO, SEL_GROUP, SEL_TRIGGER
    } nvic_sel_type;
    typedef enum logic [1:0] {
        ST_IDLE, ST_STACK, ST_RUN, ST_UNSTACK
    } nvic_state_type;
endpackage

// File: core/nvic_arbiter.sv
// Purpose: Picks the most urgent eligible interrupt.
// Assumes: Candidates already gated by pending, enable and active.
// Notes: Ties go to the lowest interrupt number.
`timescale 1ns/100ps
module nvic_arbiter (
    input wire logic [29:0] cand_in, // Eligible interrupts
    input wire logic [119:0] prio_in, // Packed four-bit priorities
    input wire logic [2:0] split_in, // Subpriority bit count
    output logic found_out, // Some candidate exists
    output logic [4:0] num_out, // Winning interrupt number
    output logic [3:0] group_out // Group part of winner priority
);
    logic [4:0] best_prio;
    logic [3:0] p;

    // Linear scan, strict compare keeps the lower number on ties
    always_comb begin
        best_prio = 5'h10;
        num_out = 5'h00;
        p = 4'h0;
        for (int i = 0; i < 30; i++) begin
            p = prio_in[i*4 +: 4];
            if (cand_in[i] && ({1'b0, p} < best_prio)) begin
                best_prio = {1'b0, p};
                num_out = 5'(i);
            end
        end
        found_out = |cand_in;
        group_out = best_prio[3:0] >> split_in;
    end
endmodule

// File: core/nvic_top.sv
// Purpose: Interrupt controller with AHB-Lite registers and core handshake.
// Assumes: Word-wide aligned accesses; handler_done_in is a one-cycle pulse.
// Notes: One handler level; preemption is only flagged, not performed.
`timescale 1ns/100ps
module nvic_top (
    input wire logic clk_sys_in, // System clock
    input wire logic sys_rst_in, // Async reset, active high
    input wire logic hsel_in, // Slave select
    input wire logic [31:0] haddr_in, // Bus address
    input wire logic [1:0] htrans_in, // Transfer type
    input wire logic hwrite_in, // Write not read
    input wire logic [2:0] hsize_in, // Transfer size
    input wire logic [31:0] hwdata_in, // Write data
    input wire logic hready_in, // Bus ready
    output logic [31:0] hrdata_out, // Read data
    output logic hreadyout_out, // Slave ready
    output logic hresp_out, // Always OKAY
    input wire logic [29:0] irq_line_in, // Peripheral requests
    input wire logic nmi_line_in, // Non-maskable request
    input wire logic core_mask_in, // Global mask from core
    input wire logic handler_done_in, // Handler return pulse
    output logic stack_save_out, // Saving core state
    output logic stack_restore_out, // Restoring core state
    output logic handler_run_out, // Handler executing
    output logic [4:0] handler_num_out, // Running interrupt number
    output logic handler_nmi_out, // Running handler is NMI
    output logic preempt_out // More urgent group waiting
);
    // Interrupt state
    logic [29:0] enable, next_enable;
    logic [29:0] pending, next_pending;
    logic [29:0] active, next_active;
    logic [29:0] line_q, next_line_q;
    logic [3:0] prio [30];
    logic [3:0] next_prio [30];
    logic [2:0] grouping, next_grouping;
    logic nmi_q, next_nmi_q;
    logic nmi_pend, next_nmi_pend;
    // Bus state
    logic dp_write, next_dp_write;
    logic [11:0] dp_addr, next_dp_addr;
    logic [31:0] next_hrdata;
    // Sequencer state
    nvic_pkg::nvic_state_type state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [4:0] next_num;
    logic next_nmi;
    logic [3:0] cur_group, next_cur_group;
    logic next_save, next_restore, next_run, next_preempt;
    // Decoded events
    logic [29:0] entry_oh, exit_oh, wr_set, wr_clr, trig_oh;
    logic [29:0] set_mask, clr_mask, cand;
    logic [119:0] prio_flat;
    logic win_found;
    logic [4:0] win_num;
    logic [3:0] win_group;
    logic can_take, take_nmi, take_irq, exit_now;
    logic addr_phase;
    nvic_pkg::nvic_sel_type wsel;

    // Register decode, shared by the read and write paths
    function automatic nvic_pkg::nvic_sel_type decode(
        input logic [11:0] a);
        nvic_pkg::nvic_sel_type s;
        s = nvic_pkg::SEL_NONE;
        if (a == nvic_pkg::OFS_SET_ENABLE) begin
            s = nvic_pkg::SEL_SET_EN;
        end else if (a == nvic_pkg::OFS_CLR_ENABLE) begin
            s = nvic_pkg::SEL_CLR_EN;
        end else if (a == nvic_pkg::OFS_SET_PENDING) begin
            s = nvic_pkg::SEL_SET_PEND;
        end else if (a == nvic_pkg::OFS_CLR_PENDING) begin
            s = nvic_pkg::SEL_CLR_PEND;
        end else if (a == nvic_pkg::OFS_ACTIVE) begin
            s = nvic_pkg::SEL_ACTIVE;
        end else if (a >= nvic_pkg::OFS_PRIO_BASE
                     && a <= nvic_pkg::OFS_PRIO_LAST) begin
            s = nvic_pkg::SEL_PRIO;
        end else if (a == nvic_pkg::OFS_GROUPING) begin
            s = nvic_pkg::SEL_GROUP;
        end else if (a == nvic_pkg::OFS_SW_TRIGGER) begin
            s = nvic_pkg::SEL_TRIGGER;
        end
        return s;
    endfunction

    // Flatten priorities for the arbiter
    generate
        for (genvar g = 0; g < 30; g++) begin : g_flat
            assign prio_flat[g*4 +: 4] = prio[g];
        end
    endgenerate

    // Disabled or active interrupts stay out of arbitration
    assign cand = pending & enable & ~active;

    nvic_arbiter u_arb (
        .cand_in(cand),
        .prio_in(prio_flat),
        .split_in(grouping),
        .found_out(win_found),
        .num_out(win_num),
        .group_out(win_group)
    );

    // Bus: address phase capture and registered read data
    always_comb begin
        addr_phase = hsel_in && htrans_in[1] && hready_in;
        next_dp_write = addr_phase && hwrite_in;
        next_dp_addr = addr_phase ? {haddr_in[11:2], 2'b00} : dp_addr;
        next_hrdata = nvic_pkg::RESET_WORD;
        if (addr_phase && !hwrite_in) begin
            case (decode({haddr_in[11:2], 2'b00}))
                nvic_pkg::SEL_SET_EN,
                nvic_pkg::SEL_CLR_EN: next_hrdata = {2'b00, enable};
                nvic_pkg::SEL_SET_PEND,
                nvic_pkg::SEL_CLR_PEND: next_hrdata = {2'b00, pending};
                nvic_pkg::SEL_ACTIVE: next_hrdata = {2'b00, active};
                nvic_pkg::SEL_PRIO: begin
                    for (int k = 0; k < 4; k++) begin
                        if (int'(haddr_in[4:2]) * 4 + k < 30) begin
                            next_hrdata[k*8 +: 4] =
                                prio[int'(haddr_in[4:2]) * 4 + k];
                        end
                    end
                end
                nvic_pkg::SEL_GROUP: next_hrdata = {29'h0, grouping};
                default: next_hrdata = nvic_pkg::RESET_WORD;
            endcase
        end
    end

    // Write strobes decoded from the held data phase
    always_comb begin
        wsel = dp_write ? decode(dp_addr) : nvic_pkg::SEL_NONE;
        wr_set = (wsel == nvic_pkg::SEL_SET_PEND) ? hwdata_in[29:0] : '0;
        wr_clr = (wsel == nvic_pkg::SEL_CLR_PEND) ? hwdata_in[29:0] : '0;
        trig_oh = '0;
        if (wsel == nvic_pkg::SEL_TRIGGER && hwdata_in[4:0] < 5'h1E) begin
            trig_oh[hwdata_in[4:0]] = 1'b1;
        end
    end

    // Sequencer: take, stack, run, chain or unstack
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_num = handler_num_out;
        next_nmi = handler_nmi_out;
        next_cur_group = cur_group;
        entry_oh = '0;
        exit_oh = '0;
        next_nmi_pend = nmi_pend | (nmi_line_in & ~nmi_q);
        take_nmi = nmi_pend;
        take_irq = win_found && !core_mask_in;
        can_take = take_nmi || take_irq;
        exit_now = (state == nvic_pkg::ST_RUN) && handler_done_in;
        if (exit_now && !handler_nmi_out) begin
            exit_oh[handler_num_out] = 1'b1;
        end
        if (can_take && (state == nvic_pkg::ST_IDLE || exit_now)) begin
            next_nmi = take_nmi;
            if (take_nmi) begin
                next_nmi_pend = nmi_line_in & ~nmi_q;
                next_cur_group = 4'h0;
            end else begin
                next_num = win_num;
                next_cur_group = win_group;
                entry_oh[win_num] = 1'b1;
            end
        end
        case (state)
            nvic_pkg::ST_IDLE: begin
                if (can_take) begin
                    next_state = nvic_pkg::ST_STACK;
                    next_cnt = nvic_pkg::STACK_LAST;
                end
            end
            nvic_pkg::ST_STACK: begin
                if (cnt == 4'h0) begin
                    next_state = nvic_pkg::ST_RUN;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            nvic_pkg::ST_RUN: begin
                // Chaining skips the restore and re-save pair
                if (exit_now && !can_take) begin
                    next_state = nvic_pkg::ST_UNSTACK;
                    next_cnt = nvic_pkg::STACK_LAST;
                end
                if (exit_now && can_take) begin
                    next_state = nvic_pkg::ST_RUN;
                end
            end
            nvic_pkg::ST_UNSTACK: begin
                if (cnt == 4'h0) begin
                    next_state = nvic_pkg::ST_IDLE;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: next_state = nvic_pkg::ST_IDLE;
        endcase
        next_save = next_state == nvic_pkg::ST_STACK;
        next_restore = next_state == nvic_pkg::ST_UNSTACK;
        next_run = next_state == nvic_pkg::ST_RUN;
        // Flag only; nesting needs a stack of contexts this block lacks
        next_preempt = next_run && take_irq && !handler_nmi_out
                       && !exit_now && win_group < cur_group;
    end

    // Pending, active, enable and priority updates
    always_comb begin
        next_line_q = irq_line_in;
        next_nmi_q = nmi_line_in;
        set_mask = (irq_line_in & ~active & ~entry_oh)
                 | (irq_line_in & ~line_q)
                 | (exit_oh & irq_line_in)
                 | wr_set | trig_oh;
        clr_mask = (wr_clr & ~irq_line_in) | entry_oh;
        next_pending = (pending & ~clr_mask) | set_mask;
        next_active = (active & ~exit_oh) | entry_oh;
        next_enable = enable;
        if (wsel == nvic_pkg::SEL_SET_EN) begin
            next_enable = enable | hwdata_in[29:0];
        end else if (wsel == nvic_pkg::SEL_CLR_EN) begin
            next_enable = enable & ~hwdata_in[29:0];
        end
        next_grouping = grouping;
        if (wsel == nvic_pkg::SEL_GROUP) begin
            next_grouping = hwdata_in[2:0];
        end
        for (int i = 0; i < 30; i++) begin
            next_prio[i] = prio[i];
            if (wsel == nvic_pkg::SEL_PRIO
                && int'(dp_addr[4:2]) == i / 4) begin
                next_prio[i] =
                    hwdata_in[(i % 4) * 8 + nvic_pkg::PRIO_LSB +: 4];
            end
        end
    end

    // Bus registers
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
            hrdata_out <= nvic_pkg::RESET_WORD;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            hrdata_out <= next_hrdata;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
    end

    // Sequencer registers, outputs straight from flops
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= nvic_pkg::ST_IDLE;
            cnt <= 4'h0;
            cur_group <= 4'h0;
            handler_num_out <= 5'h00;
            handler_nmi_out <= 1'b0;
            stack_save_out <= 1'b0;
            stack_restore_out <= 1'b0;
            handler_run_out <= 1'b0;
            preempt_out <= 1'b0;
            nmi_pend <= 1'b0;
            nmi_q <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cur_group <= next_cur_group;
            handler_num_out <= next_num;
            handler_nmi_out <= next_nmi;
            stack_save_out <= next_save;
            stack_restore_out <= next_restore;
            handler_run_out <= next_run;
            preempt_out <= next_preempt;
            nmi_pend <= next_nmi_pend;
            nmi_q <= next_nmi_q;
        end
    end

    // Interrupt state registers
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            enable <= '0;
            pending <= '0;
            active <= '0;
            line_q <= '0;
            grouping <= nvic_pkg::RESET_GROUPING;
            for (int i = 0; i < 30; i++) begin
                prio[i] <= nvic_pkg::RESET_PRIO;
            end
        end else begin
            enable <= next_enable;
            pending <= next_pending;
            active <= next_active;
            line_q <= next_line_q;
            grouping <= next_grouping;
            for (int i = 0; i < 30; i++) begin
                prio[i] <= next_prio[i];
            end
        end
    end
endmodule

// File: sim/nvic_checker_assertions.sv
// Purpose: Port-level timing checks for the interrupt controller.
// Assumes: Bound into nvic_top, single clock domain.
// Notes: Register contents are left to the bench reads.
`timescale 1ns/100ps
module nvic_checker (
    input wire logic clk_sys_in, // System clock
    input wire logic sys_rst_in, // Async reset
    input wire logic nmi_line_in, // NMI request
    input wire logic core_mask_in, // Global mask
    input wire logic handler_done_in, // Return pulse
    input wire logic hreadyout_out, // Slave ready
    input wire logic hresp_out, // Response
    input wire logic stack_save_out, // Saving state
    input wire logic stack_restore_out, // Restoring state
    input wire logic handler_run_out, // Handler running
    input wire logic [4:0] handler_num_out, // Running number
    input wire logic handler_nmi_out // Running NMI
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    // Stacking windows are exactly eight cycles long
    sequence save8_s;
        stack_save_out [*8] ##1 !stack_save_out;
    endsequence
    sequence restore8_s;
        stack_restore_out [*8] ##1 !stack_restore_out;
    endsequence
    save_then_run_a: assert property ($rose(stack_save_out) |->
        save8_s ##0 handler_run_out) else $error("bad save window");
    restore_idle_a: assert property ($rose(stack_restore_out) |->
        restore8_s ##0 !handler_run_out) else $error("bad restore");
    restore_cause_a: assert property ($rose(stack_restore_out) |->
        $past(handler_done_in)) else $error("restore without return");
    tail_chain_a: assert property (handler_run_out && handler_done_in
        |=> !stack_save_out && (handler_run_out != stack_restore_out))
        else $error("return neither chained nor restored");
    handler_hold_a: assert property (handler_run_out &&
        !handler_done_in |=> handler_run_out && $stable(handler_num_out))
        else $error("handler changed without return");
    mask_block_a: assert property ($rose(stack_save_out) &&
        $past(core_mask_in) |-> handler_nmi_out)
        else $error("masked interrupt taken");
    nmi_entry_a: assert property ($rose(nmi_line_in) &&
        !(stack_save_out || handler_run_out || stack_restore_out)
        |-> ##[1:3] (stack_save_out && handler_nmi_out))
        else $error("NMI not taken");
    save_alone_a: assert property (stack_save_out |->
        !handler_run_out && !stack_restore_out) else $error("save overlap");
    bus_okay_a: assert property (hreadyout_out && !hresp_out)
        else $error("bus not ready or not okay");
endmodule
bind nvic_top nvic_checker u_chk (.clk_sys_in, .sys_rst_in, .nmi_line_in,
    .core_mask_in, .handler_done_in, .hreadyout_out, .hresp_out,
    .stack_save_out, .stack_restore_out, .handler_run_out,
    .handler_num_out, .handler_nmi_out);

// File: sim/nvic_core_model.sv
// Purpose: Core and peripheral stand-in on the far side.
// Assumes: Handler body is a fixed number of cycles.
// Notes: hold_in keeps a level request up past its handler.
`timescale 1ns/100ps
module nvic_core_model #(
    parameter int HANDLER_CYCLES = 12 // Handler body length
) (
    input wire logic clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic run_in, // Handler running
    input wire logic [4:0] num_in, // Running number
    input wire logic [29:0] raise_in, // Assert requests
    input wire logic [29:0] drop_in, // Release requests
    input wire logic hold_in, // Keep line after service
    output logic [29:0] irq_line_out, // Request lines
    output logic done_out // Return pulse
);
    int cnt;
    logic fin;
    assign fin = run_in && !done_out && cnt == HANDLER_CYCLES;
    // Handler body, then a single return pulse
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= 0;
            done_out <= 1'b0;
        end else if (done_out) begin
            cnt <= 0;
            done_out <= 1'b0;
        end else if (run_in) begin
            cnt <= cnt + 1;
            done_out <= fin;
        end
    end
    // Line drops with the return so it is low when sampled
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_line_out <= 30'h0;
        end else begin
            irq_line_out <= (irq_line_out | raise_in) & ~drop_in;
            if (fin && !hold_in) irq_line_out[num_in] <= 1'b0;
        end
    end
endmodule

// File: sim/testbench.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: One AHB-Lite master, core model on the far side.
// Notes: Master waits on hready even though the slave is zero-wait.
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0, nmi = 1'b0, mask = 1'b0, hold = 1'b0;
    logic [29:0] raise = 30'h0, drop = 30'h0, lines;
    logic hready, hresp, done, save, rest, run, nrun, pre;
    logic [4:0] num;
    int bad_count = 0;
    int check_count = 0;
    always #25 clk = ~clk;
    nvic_top uut (.clk_sys_in(clk), .sys_rst_in(rst), .hsel_in(1'b1),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .irq_line_in(lines), .nmi_line_in(nmi), .core_mask_in(mask),
        .handler_done_in(done), .stack_save_out(save),
        .stack_restore_out(rest), .handler_run_out(run),
        .handler_num_out(num), .handler_nmi_out(nrun), .preempt_out(pre));
    nvic_core_model core (.clk_in(clk), .rst_in(rst), .run_in(run),
        .num_in(num), .raise_in(raise), .drop_in(drop), .hold_in(hold),
        .irq_line_out(lines), .done_out(done));
    // Single word transfer; address held until hready seen high
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        haddr <= {20'hE000E, a};
        hwrite <= w;
        htrans <= 2'h2;
        // Address phase stands until hready is seen high at an edge
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        // Data phase; read data taken at the edge that closes it
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
    endtask
    // Resumes just after a rising edge, ready to drive
    task automatic wait_run(input logic v);
        do @(negedge clk); while (run !== v);
        @(posedge clk);
    endtask
    task automatic end_sim;
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the expected few hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_sim;
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(nvic_pkg::OFS_SET_ENABLE, 32'h0);
        rd(nvic_pkg::OFS_ACTIVE, 32'h0);
        rd(nvic_pkg::OFS_PRIO_BASE, 32'h0);
        wr(12'h010, 32'hFFFFFFFF);
        rd(12'h010, 32'h0);
        wr(nvic_pkg::OFS_ACTIVE, 32'hFFFFFFFF);
        rd(nvic_pkg::OFS_ACTIVE, 32'h0);
        wr(nvic_pkg::OFS_SET_ENABLE, 32'hFFFFFFFF);
        rd(nvic_pkg::OFS_CLR_ENABLE, 32'h3FFFFFFF);
        wr(nvic_pkg::OFS_CLR_ENABLE, 32'h3FFFFFF0);
        rd(nvic_pkg::OFS_SET_ENABLE, 32'h0000000F);
        wr(nvic_pkg::OFS_PRIO_BASE, 32'hFFFFFFFF);
        rd(nvic_pkg::OFS_PRIO_BASE, 32'h0F0F0F0F);
        wr(nvic_pkg::OFS_PRIO_LAST, 32'h12345678);
        rd(nvic_pkg::OFS_PRIO_LAST, 32'h00000608);
        // Disabled interrupts go pending by software
        wr(nvic_pkg::OFS_SET_PENDING, 32'h00000120);
        wr(nvic_pkg::OFS_SW_TRIGGER, 32'h00000007);
        wr(nvic_pkg::OFS_SW_TRIGGER, 32'h0000001E);
        wr(nvic_pkg::OFS_SET_PENDING, 32'h00000020);
        rd(nvic_pkg::OFS_SET_PENDING, 32'h000001A0);
        chk("idle run", 32'h0, {31'h0, run});
        wr(nvic_pkg::OFS_CLR_PENDING, 32'h000001A0);
        rd(nvic_pkg::OFS_SET_PENDING, 32'h0);
        // Clear-pending is refused while a level line stays high
        raise <= 30'h200;
        @(posedge clk);
        raise <= 30'h0;
        wr(nvic_pkg::OFS_CLR_PENDING, 32'h200);
        rd(nvic_pkg::OFS_SET_PENDING, 32'h200);
        drop <= 30'h200;
        @(posedge clk);
        drop <= 30'h0;
        wr(nvic_pkg::OFS_CLR_PENDING, 32'h200);
        rd(nvic_pkg::OFS_SET_PENDING, 32'h0);
        // Level line held over the return re-enters the handler
        hold <= 1'b1;
        raise <= 30'h8;
        @(posedge clk);
        raise <= 30'h0;
        wait_run(1'b1);
        chk("num", 32'h3, {27'h0, num});
        rd(nvic_pkg::OFS_ACTIVE, 32'h8);
        rd(nvic_pkg::OFS_SET_PENDING, 32'h0);
        wait_run(1'b0);
        hold <= 1'b0;
        rd(nvic_pkg::OFS_SET_PENDING, 32'h8);
        wait_run(1'b1);
        wait_run(1'b0);
        rd(nvic_pkg::OFS_SET_PENDING, 32'h0);
        rd(nvic_pkg::OFS_ACTIVE, 32'h0);
        // Masked, then reprioritised, then chained
        wr(nvic_pkg::OFS_PRIO_BASE, 32'h00090200);
        mask <= 1'b1;
        wr(nvic_pkg::OFS_SET_PENDING, 32'h00000006);
        repeat (4) @(posedge clk);
        chk("masked run", 32'h0, {31'h0, run});
        wr(nvic_pkg::OFS_PRIO_BASE, 32'h00010200);
        mask <= 1'b0;
        wait_run(1'b1);
        chk("first num", 32'h2, {27'h0, num});
        chk("calm preempt", 32'h0, {31'h0, pre});
        // Group 0 request behind a group 1 handler is flagged only
        wr(nvic_pkg::OFS_SET_PENDING, 32'h00000008);
        repeat (2) @(negedge clk);
        chk("preempt", 32'h1, {31'h0, pre});
        do @(negedge clk); while (num === 5'h2 && run === 1'b1);
        chk("chain num", 32'h3, {27'h0, num});
        chk("chain run", 32'h1, {31'h0, run});
        chk("chain restore", 32'h0, {31'h0, rest});
        @(posedge clk);
        wait_run(1'b0);
        wr(nvic_pkg::OFS_GROUPING, 32'hFFFFFFFF);
        rd(nvic_pkg::OFS_GROUPING, 32'h00000007);
        // Non-maskable request gets through the global mask
        repeat (10) @(posedge clk);
        mask <= 1'b1;
        nmi <= 1'b1;
        wait_run(1'b1);
        chk("nmi run", 32'h1, {31'h0, nrun});
        nmi <= 1'b0;
        wait_run(1'b0);
        repeat (10) @(posedge clk);
        end_sim;
    end
endmodule
